// [include/slcc_pkg.sv]
// Shared constants and types for the line B channel control block.
// Assumes a single 25 MHz clock and a byte-wide register port.
package slcc_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_LINK_CTRL_B  = 8'h07;
  localparam logic [7:0] ADDR_ERR_FLAGS_A  = 8'h08;
  localparam logic [7:0] ADDR_CYCLE_TIME_B = 8'h0F;
  localparam logic [7:0] LINK_CTRL_B_RST   = 8'h00;
  localparam logic [7:0] ERR_FLAGS_A_RST   = 8'h00;
  localparam logic [7:0] CYCLE_TIME_B_RST  = 8'h00;

  // ==========================================================
  // Field positions
  localparam int BIT_SEND      = 0;
  localparam int BIT_TIMER_ARM = 1;
  localparam int BIT_RX_CLR    = 2;
  localparam int BIT_TX_CLR    = 3;
  localparam int BIT_WAKE      = 4;
  localparam int BIT_EST       = 5;
  localparam int RATE_LO       = 6;
  localparam int RATE_HI       = 7;
  localparam int BIT_TX_FAIL_A = 7;

  // ==========================================================
  // Rates and states
  typedef enum logic [1:0] {
    RATE_FAIL  = 2'h0,
    RATE_4K8   = 2'h1,
    RATE_38K4  = 2'h2,
    RATE_230K4 = 2'h3
  } slcc_rate_t;

  typedef enum logic [1:0] {
    EST_IDLE  = 2'h0,
    EST_WAKE  = 2'h1,
    EST_PROBE = 2'h3,
    EST_WAIT  = 2'h2
  } slcc_est_t;

  typedef enum logic {
    TX_IDLE = 1'h0,
    TX_RUN  = 1'h1
  } slcc_tx_t;

  // ==========================================================
  // Timing, sizes
  localparam int CLK_PERIOD_NS  = 40;
  localparam int WAKE_TIME_NS   = 80000;
  localparam int WAKE_CYC       = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROBE_WAIT_NS  = 400000;
  localparam int PROBE_WAIT_CYC = PROBE_WAIT_NS / CLK_PERIOD_NS;
  localparam int CYCLE_UNIT_NS  = 100000;
  localparam int CYCLE_UNIT_CYC = CYCLE_UNIT_NS / CLK_PERIOD_NS;
  localparam int DATA_W         = 8;
  localparam int FIFO_DEPTH     = 8;

endpackage

// [include/slcc_fifo_if.sv]
// Stream carrier between the control block and its transmit queue.
// Assumes both ends share clk_in.
`timescale 1ns/1ps
interface slcc_fifo_if #(parameter int W = 8);
  logic [W-1:0] wr_data;
  logic         wr_valid;
  logic         wr_ready;
  logic [W-1:0] rd_data;
  logic         rd_valid;
  logic         rd_ready;
  logic         clear;
  modport store (input wr_data, wr_valid, rd_ready, clear,
                 output wr_ready, rd_data, rd_valid);
  modport user  (output wr_data, wr_valid, rd_ready, clear,
                 input wr_ready, rd_data, rd_valid);
endinterface

// [src/slcc_fifo.sv]
// Transmit queue: synchronous FIFO with valid/ready on both sides.
// Assumes a synchronous active-low reset; clear empties it in one cycle.
`timescale 1ns/1ps
module slcc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  slcc_fifo_if.store q
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             push;
  logic             pop;

  assign q.wr_ready = (count != (PW+1)'(DEPTH));
  assign q.rd_valid = (count != '0);
  assign q.rd_data  = mem[rd_ptr];
  assign push       = q.wr_valid && q.wr_ready && !q.clear;
  assign pop        = q.rd_valid && q.rd_ready && !q.clear;

  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem[wr_ptr] <= q.wr_data;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || q.clear)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
        count <= count + 1'b1;
      end
      else if (pop && !push)
      begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// [src/slcc_cycle_timer.sv]
// Autonomous cycle timer: armed, then started by an event, ticks each period.
// Assumes period_in is stable while running; a zero period never ticks.
`timescale 1ns/1ps
module slcc_cycle_timer #(
  parameter int CNT_W = 20
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             arm_in,
  input  wire logic             start_in,
  input  wire logic [CNT_W-1:0] period_in,
  output logic                  running_out,
  output logic                  tick_out
);
  logic [CNT_W-1:0] cnt;

  assign tick_out = running_out && (cnt == '0) && (period_in != '0);

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || !arm_in)
    begin
      // Disarm stops at once, mid-cycle included
      running_out <= 1'b0;
      cnt         <= '0;
    end
    else if (start_in && !running_out)
    begin
      running_out <= 1'b1;
      cnt         <= period_in - 1'b1;
    end
    else if (tick_out)
    begin
      cnt <= period_in - 1'b1;
    end
    else if (running_out && cnt != '0)
    begin
      cnt <= cnt - 1'b1;
    end
  end
endmodule

// [src/slcc_top.sv]
// Line B link control register, establish sequencer, wake pulse, send path,
// cycle timer and the channel A clear-on-read error flags.
// Assumes a decoded byte register port and a line-side serializer/probe unit.
`timescale 1ns/1ps

// Contract
// - Rate field: 00 fail, 01 4.8k, 10 38.4k, 11 230.4k.
// - Successful establish sequence stores the detected rate in the field.
// - Writing establish bit starts sequence; success raises irq, clears bit. The code starts it only while framer_enable_b_in is high.
// - Current limit boosted during sequencer wake pulse; setting bits untouched.
// - Success makes remote cycle time readable.
// - Failure raises irq, clears establish bit, rate field becomes 00.
// - Wake bit gives one wake request, then transceiver receives.
// - Wake bit self-clears when the wake request finishes.
// - Transmit queue clear bit empties the transmit queue.
// - Receive queue clear bit empties the receive queue.
// - Arming the cycle timer does not start it.
// - Armed timer starts on send bit or trigger command.
// - Disarming stops the timer immediately, even mid-cycle.
// - Send bit switches transceiver to transmit and sends the queue.
// - Message done and queue empty returns transceiver to receive.
// - Send bit clears itself once the send is accepted.
// - Error flags A read-only, reset to zero, cleared on read.
// - Bit 7 of error flags A marks a failed channel A transmission.
module slcc_top #(
  parameter int DATA_W         = slcc_pkg::DATA_W,
  parameter int FIFO_DEPTH     = slcc_pkg::FIFO_DEPTH,
  parameter int PROBE_WAIT_CYC = slcc_pkg::PROBE_WAIT_CYC
) (
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic [7:0]        reg_addr_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  input  wire logic [7:0]        reg_wdata_in,
  output logic      [7:0]        reg_rdata_out,
  input  wire logic              framer_enable_b_in,
  input  wire logic              trigger_cmd_b_in,
  input  wire logic [7:0]        err_events_a_in,
  input  wire logic [DATA_W-1:0] tx_data_in,
  input  wire logic              tx_valid_in,
  output logic                   tx_ready_out,
  output logic      [DATA_W-1:0] line_b_data_out,
  output logic                   line_b_valid_out,
  input  wire logic              line_b_ready_in,
  output logic                   line_b_tx_mode_out,
  output logic                   line_b_wake_out,
  output logic                   line_b_boost_out,
  output logic                   line_b_probe_out,
  output logic      [1:0]        line_b_probe_rate_out,
  input  wire logic              line_b_reply_ok_in,
  input  wire logic [7:0]        line_b_reply_cycle_in,
  output logic                   rx_fifo_clear_b_out,
  output logic                   wake_done_irq_out
);
  localparam int CNT_W   = 24;
  localparam int TMR_W   = 20;
  localparam int WAKE_LAST  = slcc_pkg::WAKE_CYC - 1;
  localparam int PROBE_LAST = PROBE_WAIT_CYC - 1;

  // ==========================================================
  // Registers and state
  logic [7:0]         link_control_b;
  logic [7:0]         error_flags_a;
  logic [7:0]         cycle_time_b;
  slcc_pkg::slcc_est_t est_state;
  slcc_pkg::slcc_tx_t  tx_state;
  slcc_pkg::slcc_rate_t try_rate;
  logic [CNT_W-1:0]   wake_cnt;
  logic [CNT_W-1:0]   probe_cnt;
  logic               wake_active;
  logic               manual_busy;

  logic ctrl_wr;
  logic err_rd;
  logic wake_end;
  logic manual_start;
  logic manual_done;
  logic est_start;
  logic est_success;
  logic est_fail;
  logic send_accept;
  logic timer_start;
  logic timer_running;
  logic timer_tick;
  logic [TMR_W-1:0] timer_period;

  slcc_fifo_if #(.W(DATA_W)) txq ();

  assign ctrl_wr = reg_wr_in && (reg_addr_in == slcc_pkg::ADDR_LINK_CTRL_B);
  assign err_rd  = reg_rd_in && (reg_addr_in == slcc_pkg::ADDR_ERR_FLAGS_A);

  // ==========================================================
  // Transmit queue
  assign txq.wr_data      = tx_data_in;
  assign txq.wr_valid     = tx_valid_in;
  assign tx_ready_out     = txq.wr_ready;
  assign txq.rd_ready     = (tx_state == slcc_pkg::TX_RUN) && line_b_ready_in;
  assign line_b_data_out  = txq.rd_data;
  assign line_b_valid_out = (tx_state == slcc_pkg::TX_RUN) && txq.rd_valid;
  assign txq.clear        = link_control_b[slcc_pkg::BIT_TX_CLR];
  assign rx_fifo_clear_b_out = link_control_b[slcc_pkg::BIT_RX_CLR];

  slcc_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_txq (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .q        (txq)
  );

  // ==========================================================
  // Wake pulse, shared by manual and sequencer use
  assign wake_end = wake_active && (wake_cnt == CNT_W'(WAKE_LAST));
  assign manual_start = link_control_b[slcc_pkg::BIT_WAKE] && !manual_busy && !wake_active
                        && (est_state == slcc_pkg::EST_IDLE) && (tx_state == slcc_pkg::TX_IDLE);
  assign manual_done  = manual_busy && wake_end;
  assign est_start = link_control_b[slcc_pkg::BIT_EST] && framer_enable_b_in && !wake_active
                     && !manual_busy && (est_state == slcc_pkg::EST_IDLE)
                     && (tx_state == slcc_pkg::TX_IDLE);

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      wake_active <= 1'b0;
      wake_cnt    <= '0;
    end
    else if (manual_start || est_start)
    begin
      wake_active <= 1'b1;
      wake_cnt    <= '0;
    end
    else if (wake_active)
    begin
      wake_active <= !wake_end;
      wake_cnt    <= wake_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      manual_busy <= 1'b0;
    end
    else if (manual_start)
    begin
      manual_busy <= 1'b1;
    end
    else if (manual_done)
    begin
      manual_busy <= 1'b0;
    end
  end

  assign line_b_wake_out  = wake_active;
  // boost only while sequencer wakes the line
  assign line_b_boost_out = wake_active && (est_state == slcc_pkg::EST_WAKE);

  // ==========================================================
  // Establish sequencer: wake, then probe fastest rate downward
  assign est_success = (est_state == slcc_pkg::EST_WAIT) && line_b_reply_ok_in;
  assign est_fail    = (est_state == slcc_pkg::EST_WAIT) && !line_b_reply_ok_in
                       && (probe_cnt == CNT_W'(PROBE_LAST))
                       && (try_rate == slcc_pkg::RATE_4K8);

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      est_state <= slcc_pkg::EST_IDLE;
      try_rate  <= slcc_pkg::RATE_230K4;
      probe_cnt <= '0;
    end
    else
    begin
      case (est_state)
        slcc_pkg::EST_IDLE:
        begin
          if (est_start)
          begin
            est_state <= slcc_pkg::EST_WAKE;
          end
        end
        slcc_pkg::EST_WAKE:
        begin
          if (wake_end)
          begin
            est_state <= slcc_pkg::EST_PROBE;
            try_rate  <= slcc_pkg::RATE_230K4;
          end
        end
        slcc_pkg::EST_PROBE:
        begin
          est_state <= slcc_pkg::EST_WAIT;
          probe_cnt <= '0;
        end
        default:
        begin
          if (est_success || est_fail)
          begin
            est_state <= slcc_pkg::EST_IDLE;
          end
          else if (probe_cnt == CNT_W'(PROBE_LAST))
          begin
            try_rate  <= slcc_pkg::slcc_rate_t'(try_rate - 2'h1);
            est_state <= slcc_pkg::EST_PROBE;
          end
          else
          begin
            probe_cnt <= probe_cnt + 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      line_b_probe_out      <= 1'b0;
      line_b_probe_rate_out <= slcc_pkg::RATE_FAIL;
      wake_done_irq_out     <= 1'b0;
    end
    else
    begin
      line_b_probe_out      <= (est_state == slcc_pkg::EST_PROBE);
      line_b_probe_rate_out <= try_rate;
      wake_done_irq_out     <= est_success || est_fail;
    end
  end

  // remote cycle time captured on success
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      cycle_time_b <= slcc_pkg::CYCLE_TIME_B_RST;
    end
    else if (est_success)
    begin
      cycle_time_b <= line_b_reply_cycle_in;
    end
  end

  // ==========================================================
  // Send path
  assign send_accept = link_control_b[slcc_pkg::BIT_SEND] && (tx_state == slcc_pkg::TX_IDLE)
                       && !wake_active && (est_state == slcc_pkg::EST_IDLE);

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      tx_state <= slcc_pkg::TX_IDLE;
    end
    else
    begin
      case (tx_state)
        slcc_pkg::TX_IDLE:
        begin
          // send or timer tick opens transmit
          if (send_accept || (timer_tick && !wake_active && est_state == slcc_pkg::EST_IDLE))
          begin
            tx_state <= slcc_pkg::TX_RUN;
          end
        end
        default:
        begin
          if (!txq.rd_valid)
          begin
            tx_state <= slcc_pkg::TX_IDLE;
          end
        end
      endcase
    end
  end

  assign line_b_tx_mode_out = (tx_state == slcc_pkg::TX_RUN);

  // ==========================================================
  // Cycle timer
  // start on send or trigger command
  assign timer_start  = send_accept || trigger_cmd_b_in;
  assign timer_period = TMR_W'(cycle_time_b) * TMR_W'(slcc_pkg::CYCLE_UNIT_CYC);

  slcc_cycle_timer #(
    .CNT_W (TMR_W)
  ) u_timer (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .arm_in      (link_control_b[slcc_pkg::BIT_TIMER_ARM]),
    .start_in    (timer_start),
    .period_in   (timer_period),
    .running_out (timer_running),
    .tick_out    (timer_tick)
  );

  // ==========================================================
  // Link control register; software set wins over hardware clear
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      link_control_b <= slcc_pkg::LINK_CTRL_B_RST;
    end
    else if (ctrl_wr)
    begin
      link_control_b <= reg_wdata_in;
    end
    else
    begin
      if (send_accept)
      begin
        link_control_b[slcc_pkg::BIT_SEND] <= 1'b0;
      end
      if (manual_done)
      begin
        link_control_b[slcc_pkg::BIT_WAKE] <= 1'b0;
      end
      // Queue flushes last exactly one cycle
      link_control_b[slcc_pkg::BIT_TX_CLR] <= 1'b0;
      link_control_b[slcc_pkg::BIT_RX_CLR] <= 1'b0;
      if (est_success)
      begin
        link_control_b[slcc_pkg::RATE_HI:slcc_pkg::RATE_LO] <= try_rate;
        link_control_b[slcc_pkg::BIT_EST] <= 1'b0;
      end
      if (est_fail)
      begin
        link_control_b[slcc_pkg::RATE_HI:slcc_pkg::RATE_LO] <= slcc_pkg::RATE_FAIL;
        link_control_b[slcc_pkg::BIT_EST] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Error flags A: read clears, a same-cycle event survives
  // clear on read, set wins
  // transmit failure lands in bit 7
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      error_flags_a <= slcc_pkg::ERR_FLAGS_A_RST;
    end
    else
    begin
      error_flags_a <= (err_rd ? 8'h00 : error_flags_a) | err_events_a_in;
    end
  end

  // ==========================================================
  // Read data, registered; unmapped reads return zero
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      reg_rdata_out <= 8'h00;
    end
    else if (reg_rd_in)
    begin
      if (reg_addr_in == slcc_pkg::ADDR_LINK_CTRL_B)
      begin
        reg_rdata_out <= link_control_b;
      end
      else if (reg_addr_in == slcc_pkg::ADDR_ERR_FLAGS_A)
      begin
        reg_rdata_out <= error_flags_a;
      end
      else if (reg_addr_in == slcc_pkg::ADDR_CYCLE_TIME_B)
      begin
        reg_rdata_out <= cycle_time_b;
      end
      else
      begin
        reg_rdata_out <= 8'h00;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_est_clear;
    est_success && !ctrl_wr |=> !link_control_b[slcc_pkg::BIT_EST] && wake_done_irq_out;
  endproperty
  a_est_clear: assert property (p_est_clear) else $error("establish bit not cleared");

  property p_rate_store;
    est_success && !ctrl_wr |=> link_control_b[7:6] == $past(try_rate);
  endproperty
  a_rate_store: assert property (p_rate_store) else $error("rate not stored");

  property p_boost;
    line_b_wake_out |-> line_b_boost_out == !manual_busy;
  endproperty
  a_boost: assert property (p_boost) else $error("boost outside sequencer wake");

  property p_fail;
    est_fail && !ctrl_wr |=> link_control_b[7:5] == 3'h0 && wake_done_irq_out;
  endproperty
  a_fail: assert property (p_fail) else $error("failure not reported");

  property p_wake_len;
    $rose(line_b_wake_out) |-> line_b_wake_out[*8] ##0 !line_b_tx_mode_out;
  endproperty
  a_wake_len: assert property (p_wake_len) else $error("wake pulse too short");

  property p_wake_clear;
    manual_done && !ctrl_wr |=> !link_control_b[slcc_pkg::BIT_WAKE] && !line_b_wake_out;
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("wake bit stuck");

  property p_timer_stop;
    !link_control_b[slcc_pkg::BIT_TIMER_ARM] |=> !timer_running;
  endproperty
  a_timer_stop: assert property (p_timer_stop) else $error("timer runs disarmed");

  property p_arm_idle;
    !timer_running && !timer_start |=> !timer_running;
  endproperty
  a_arm_idle: assert property (p_arm_idle) else $error("timer started by itself");

  property p_send;
    send_accept && !ctrl_wr |=> line_b_tx_mode_out && !link_control_b[slcc_pkg::BIT_SEND];
  endproperty
  a_send: assert property (p_send) else $error("send not taken");

  property p_rx_return;
    line_b_tx_mode_out && !txq.rd_valid |=> !line_b_tx_mode_out;
  endproperty
  a_rx_return: assert property (p_rx_return) else $error("transmit mode held");

  property p_err_clear;
    err_rd |=> error_flags_a == $past(err_events_a_in);
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("flags not cleared");

  property p_tx_fail;
    err_events_a_in[slcc_pkg::BIT_TX_FAIL_A] |=> error_flags_a[slcc_pkg::BIT_TX_FAIL_A];
  endproperty
  a_tx_fail: assert property (p_tx_fail) else $error("transmit fail lost");

endmodule

// [sim/slcc_remote_model.sv]
// Remote device on line B: byte sink and probe responder.
// Assumes the control block's clock and reset.
`timescale 1ns/1ps
module slcc_remote_model (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [1:0] answer_in,
  input  wire logic [7:0] cycle_in,
  input  wire logic       stall_in,
  input  wire logic       valid_in,
  input  wire logic       probe_in,
  input  wire logic [1:0] rate_in,
  output logic            ready_out,
  output logic            ok_out,
  output logic      [7:0] cyc_out,
  output int              count_out
);
  logic [2:0] age;
  // ==========
  // Probe reply
  // Answers own rate only; 0 never answers
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      age <= 3'h0;
    else if (probe_in)
      age <= {2'h0, (rate_in == answer_in) && (answer_in != 2'h0)};
    else if (age != 3'h0 && age != 3'h7)
      age <= age + 3'h1;
  end
  assign ok_out = age[2] && (age != 3'h7);
  // Junk outside a reply, never a stale value
  assign cyc_out = ok_out ? cycle_in : ~cycle_in;
  // ==========
  // Byte sink
  assign ready_out = !stall_in;
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      count_out <= 0;
    else if (valid_in && ready_out)
      count_out <= count_out + 1;
  end
endmodule

// [sim/sensor_link_channel_control_test.sv]
// Self-checking bench for the line B channel control block.
// Assumes the remote model on line B and a 25 MHz clock.
`timescale 1ns/1ps
module sensor_link_channel_control_test;
  localparam logic [7:0] CTRL = slcc_pkg::ADDR_LINK_CTRL_B;
  localparam logic [7:0] ERR  = slcc_pkg::ADDR_ERR_FLAGS_A;
  typedef struct {logic [1:0] ans; logic [7:0] cyc; logic [7:0] ctrl;} slcc_row_t;
  slcc_row_t rows [4] = '{'{2'h0, 8'h05, 8'h00}, '{2'h3, 8'h09, 8'hC0},
                          '{2'h2, 8'h07, 8'h80}, '{2'h1, 8'h01, 8'h40}};
  logic       clk_in, rst_n_in, reg_wr_in, reg_rd_in, framer_enable_b_in, trigger_cmd_b_in;
  logic       tx_valid_in, tx_ready_out, line_b_valid_out, line_b_ready_in;
  logic       line_b_tx_mode_out, line_b_wake_out, line_b_boost_out, line_b_probe_out;
  logic       line_b_reply_ok_in, rx_fifo_clear_b_out, wake_done_irq_out, stall;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, err_events_a_in, tx_data_in, cyc;
  logic [7:0] line_b_data_out, line_b_reply_cycle_in;
  logic [1:0] line_b_probe_rate_out, answer;
  logic       prev_mode = 1'b0;
  int         failures = 0, total_checks = 0, cycles = 0, rises = 0, clears = 0, count, n, base;

  slcc_top #(.PROBE_WAIT_CYC(20)) slcc_top_i (.clk_in, .rst_n_in, .reg_addr_in, .reg_wr_in,
    .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .framer_enable_b_in, .trigger_cmd_b_in,
    .err_events_a_in, .tx_data_in, .tx_valid_in, .tx_ready_out, .line_b_data_out,
    .line_b_valid_out, .line_b_ready_in, .line_b_tx_mode_out, .line_b_wake_out,
    .line_b_boost_out, .line_b_probe_out, .line_b_probe_rate_out, .line_b_reply_ok_in,
    .line_b_reply_cycle_in, .rx_fifo_clear_b_out, .wake_done_irq_out);
  slcc_remote_model slcc_remote_model_i (.clk_in, .rst_n_in, .answer_in(answer),
    .cycle_in(cyc), .stall_in(stall), .valid_in(line_b_valid_out),
    .probe_in(line_b_probe_out), .rate_in(line_b_probe_rate_out), .ready_out(line_b_ready_in),
    .ok_out(line_b_reply_ok_in), .cyc_out(line_b_reply_cycle_in), .count_out(count));

  // ==========
  // Clock, watchdog, event counters
  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  always @(negedge clk_in)
  begin
    cycles++;
    if (line_b_tx_mode_out === 1'b1 && !prev_mode)
      rises++;
    prev_mode = line_b_tx_mode_out;
    if (rx_fifo_clear_b_out === 1'b1)
      clears++;
    if (cycles == 40000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  // ==========
  // Tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge clk_in);
    reg_rd_in = 1'b0;
    @(negedge clk_in);
    chk(16'(reg_rdata_out), 16'(e));
  endtask
  task automatic push(input logic [7:0] d);
    @(negedge clk_in);
    tx_data_in = d;
    tx_valid_in = 1'b1;
    @(negedge clk_in);
    tx_valid_in = 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ==========
  // Main sequence
  initial
  begin
    {rst_n_in, reg_wr_in, reg_rd_in, framer_enable_b_in, trigger_cmd_b_in} = 5'h00;
    {reg_addr_in, reg_wdata_in, err_events_a_in, tx_data_in, cyc} = 40'h0;
    {tx_valid_in, stall, answer} = 4'h0;
    repeat (4) @(negedge clk_in);
    rst_n_in = 1'b1;
    rd(CTRL, slcc_pkg::LINK_CTRL_B_RST);
    rd(ERR, slcc_pkg::ERR_FLAGS_A_RST);
    wr(CTRL, 8'h20);
    repeat (50) @(negedge clk_in);
    chk(16'(line_b_wake_out), 16'h0000);
    wr(CTRL, 8'h00);
    framer_enable_b_in = 1'b1;
    foreach (rows[i])
    begin
      answer = rows[i].ans;
      cyc = rows[i].cyc;
      wr(CTRL, 8'h20);
      repeat (100) @(negedge clk_in);
      chk(16'(line_b_boost_out), 16'h0001);
      n = 0;
      while (wake_done_irq_out !== 1'b1 && n < 3000)
      begin
        @(negedge clk_in);
        n++;
      end
      chk(16'(wake_done_irq_out), 16'h0001);
      rd(CTRL, rows[i].ctrl);
      if (rows[i].ctrl != 8'h00)
        rd(slcc_pkg::ADDR_CYCLE_TIME_B, rows[i].cyc);
      $display("establish row %0d done", i);
    end
    stall = 1'b1;
    push(8'hA1);
    push(8'hB2);
    push(8'hC3);
    base = count;
    wr(CTRL, 8'h01);
    repeat (2) @(negedge clk_in);
    chk(16'(line_b_tx_mode_out), 16'h0001);
    chk(16'(line_b_data_out), 16'h00A1);
    rd(CTRL, 8'h00);
    stall = 1'b0;
    repeat (20) @(negedge clk_in);
    chk(16'(count - base), 16'h0003);
    chk(16'(line_b_tx_mode_out), 16'h0000);
    stall = 1'b1;
    for (int k = 0; k < 8; k++)
      push(8'(k));
    chk(16'(tx_ready_out), 16'h0000);
    wr(CTRL, 8'h08);
    repeat (2) @(negedge clk_in);
    chk(16'(tx_ready_out), 16'h0001);
    // Sink open, so a surviving byte would be counted
    stall = 1'b0;
    base = count;
    wr(CTRL, 8'h01);
    repeat (20) @(negedge clk_in);
    chk(16'(count - base), 16'h0000);
    base = clears;
    wr(CTRL, 8'h04);
    repeat (3) @(negedge clk_in);
    chk(16'(clears - base), 16'h0001);
    $display("send and queue tests done");
    wr(CTRL, 8'h10);
    @(negedge clk_in);
    chk(16'({line_b_wake_out, line_b_boost_out}), 16'h0002);
    n = 0;
    while (line_b_wake_out === 1'b1 && n < 2100)
    begin
      n++;
      @(negedge clk_in);
    end
    chk(16'(n), 16'(slcc_pkg::WAKE_CYC));
    rd(CTRL, 8'h00);
    chk(16'(line_b_tx_mode_out), 16'h0000);
    err_events_a_in = 8'h80;
    @(negedge clk_in);
    err_events_a_in = 8'h00;
    rd(ERR, 8'h80);
    rd(ERR, 8'h00);
    wr(ERR, 8'hFF);
    rd(ERR, 8'h00);
    rd(8'h3C, 8'h00);
    $display("wake and error flag tests done");
    base = rises;
    wr(CTRL, 8'h02);
    repeat (3000) @(negedge clk_in);
    chk(16'(rises - base), 16'h0000);
    trigger_cmd_b_in = 1'b1;
    @(negedge clk_in);
    trigger_cmd_b_in = 1'b0;
    repeat (2600) @(negedge clk_in);
    chk(16'(rises - base), 16'h0001);
    wr(CTRL, 8'h00);
    base = rises;
    repeat (3000) @(negedge clk_in);
    chk(16'(rises - base), 16'h0000);
    $display("cycle timer test done");
    // Mid-run reset with state and a pending event
    wr(CTRL, 8'hC2);
    err_events_a_in = 8'h80;
    rst_n_in = 1'b0;
    repeat (2) @(negedge clk_in);
    err_events_a_in = 8'h00;
    rst_n_in = 1'b1;
    rd(CTRL, slcc_pkg::LINK_CTRL_B_RST);
    rd(ERR, slcc_pkg::ERR_FLAGS_A_RST);
    $display("reset test done");
    tally_and_finish();
  end
endmodule
